// >>> verilog/alsi_pkg.sv
package alsi_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int ACK_DELAY_NS    = 400;
  localparam int LOAD_PULSE_NS   = 150;
  localparam int CLEAR_PULSE_NS  = 150;
  localparam int ACK_DELAY_CYC   = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_PULSE_CYC  = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  localparam logic [CNT_W-1:0] ACK_DELAY_CNT   = CNT_W'(ACK_DELAY_CYC);
  localparam logic [CNT_W-1:0] LOAD_PULSE_CNT  = CNT_W'(LOAD_PULSE_CYC);
  localparam logic [CNT_W-1:0] CLEAR_PULSE_CNT = CNT_W'(CLEAR_PULSE_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO        = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE         = 8'h01;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATE    = 4'hC;
  localparam int CTRL_VEC_LSB   = 0;
  localparam int CTRL_VEC_W     = 6;
  localparam int CTRL_LEVEL_LSB = 6;
  localparam int CTRL_LEVEL_W   = 2;
  localparam int CTRL_W         = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h06;
  localparam int EVT_TX_LOAD  = 0;
  localparam int EVT_RX_CLEAR = 1;
  localparam int EVT_RX_VEC   = 2;
  localparam int EVT_TX_VEC   = 3;
  localparam int EVT_W        = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Vector drive
  // ----------------------------------------------------------------
  localparam int VEC_W = 9;
  localparam logic [VEC_W-1:0] VEC_OE_N_IDLE  = 9'h1FF;
  localparam logic [VEC_W-1:0] VEC_OE_N_DRIVE = 9'h003;
  localparam logic [3:0]       REQ_NONE       = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strobe;
    logic match;
    logic dir;
    logic c0;
    logic a2;
    logic a1;
    logic a0;
    logic grant;
    logic vec_taken;
  } alsi_pins_t;

  localparam alsi_pins_t PINS_RESET = 9'h000;

  typedef struct packed {
    logic rsta_to_bus;
    logic rhld_to_bus;
    logic tsta_to_bus;
    logic bus_to_rsta;
    logic bus_to_rhld;
    logic bus_to_tsta;
    logic bus_to_thld;
  } alsi_sel_t;

  localparam alsi_sel_t SEL_NONE = 7'h00;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_ACK  = 3'b100
  } alsi_bus_state_t;

  typedef enum logic [2:0] {
    IRQ_IDLE = 3'b001,
    IRQ_REQ  = 3'b010,
    IRQ_VEC  = 3'b100
  } alsi_irq_state_t;

  typedef struct packed {
    alsi_pins_t s1;
    alsi_pins_t s2;
    alsi_pins_t s3;
    alsi_pins_t q;
  } alsi_sync_st_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pulse;
  } alsi_shot_st_t;

endpackage : alsi_pkg

// >>> verilog/alsi_pin_sync.sv
`timescale 1ns/1ps
module alsi_pin_sync (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire alsi_pkg::alsi_pins_t pins,
  output alsi_pkg::alsi_pins_t      pins_q
);

  alsi_pkg::alsi_sync_st_t st_ff;
  alsi_pkg::alsi_sync_st_t nxt_st;

  // ----------------------------------------------------------------
  // Three stages; a bit changes only once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < $bits(alsi_pkg::alsi_pins_t); i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= {4{alsi_pkg::PINS_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins_q = st_ff.q;

endmodule : alsi_pin_sync

// >>> verilog/alsi_oneshot.sv
`timescale 1ns/1ps
module alsi_oneshot #(
  parameter logic [alsi_pkg::CNT_W-1:0] WIDTH_CYC = 8'h01
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic trig,
  output logic      pulse
);

  alsi_pkg::alsi_shot_st_t st_ff;
  alsi_pkg::alsi_shot_st_t nxt_st;

  // ----------------------------------------------------------------
  // Non-retriggerable: a trigger during the pulse is ignored
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.pulse) begin
      if (trig) begin
        nxt_st.pulse = 1'b1;
        nxt_st.cnt   = WIDTH_CYC - alsi_pkg::CNT_ONE;
      end
    end else if (st_ff.cnt == alsi_pkg::CNT_ZERO) begin
      nxt_st.pulse = 1'b0;
    end else begin
      nxt_st.cnt = st_ff.cnt - alsi_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;

endmodule : alsi_oneshot

// >>> verilog/alsi_line_bus_slave.sv
`timescale 1ns/1ps
module alsi_line_bus_slave (
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic                          master_sync_strobe,
  input  wire logic                          address_match,
  input  wire logic                          direction_control,
  input  wire logic                          byte_control,
  input  wire logic                          reg_select_bit2,
  input  wire logic                          reg_select_bit1,
  input  wire logic                          byte_address_bit,
  input  wire logic                          bus_grant,
  input  wire logic                          vector_taken,
  input  wire logic                          receive_done_flag,
  input  wire logic                          transmit_ready_flag,
  input  wire logic                          receive_irq_enable,
  input  wire logic                          transmit_irq_enable,
  input  wire logic [alsi_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [alsi_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [alsi_pkg::DATA_W-1:0]        reg_rdata,
  output alsi_pkg::alsi_sel_t                reg_select,
  output logic                               slave_sync_ack,
  output logic                               transmit_load_pulse,
  output logic                               receive_clear_pulse,
  output logic [3:0]                         request_lines,
  output logic [alsi_pkg::VEC_W-1:0]         vector_data,
  output logic [alsi_pkg::VEC_W-1:0]         vector_oe_n,
  output logic                               irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    alsi_pkg::alsi_bus_state_t bst;
    logic [alsi_pkg::CNT_W-1:0] cnt;
    alsi_pkg::alsi_sel_t        sel;
    logic                       ack;
    logic                       load_trig;
    logic                       clr_trig;
    alsi_pkg::alsi_irq_state_t  ist;
    logic                       src_tx;
    logic                       rx_armed;
    logic                       tx_armed;
    logic [3:0]                 req_lines;
    logic [alsi_pkg::VEC_W-1:0] vec_data;
    logic [alsi_pkg::VEC_W-1:0] vec_oe_n;
    logic [alsi_pkg::CTRL_W-1:0] ctrl;
    logic [alsi_pkg::EVT_W-1:0] stat;
    logic [alsi_pkg::EVT_W-1:0] mask;
    logic [alsi_pkg::DATA_W-1:0] rdata;
    logic                       irq;
  } alsi_top_st_t;

  alsi_top_st_t         st_ff;
  alsi_top_st_t         nxt_st;
  alsi_pkg::alsi_pins_t pins_raw;
  alsi_pkg::alsi_pins_t pin;
  logic                 load_busy;
  logic                 clr_busy;
  logic                 addr_en;
  logic                 rx_cond;
  logic                 tx_cond;
  logic                 rx_req;
  logic                 tx_req;
  logic [alsi_pkg::EVT_W-1:0] evt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic alsi_pkg::alsi_sel_t decode_sel(input logic dir, input logic a2, input logic a1);
    alsi_pkg::alsi_sel_t s;
    s = alsi_pkg::SEL_NONE;
    unique case ({dir, a2, a1})
      3'h0: s.rsta_to_bus = 1'b1;
      3'h1: s.rhld_to_bus = 1'b1;
      3'h2: s.tsta_to_bus = 1'b1;
      3'h3: s = alsi_pkg::SEL_NONE;
      3'h4: s.bus_to_rsta = 1'b1;
      3'h5: s.bus_to_rhld = 1'b1;
      3'h6: s.bus_to_tsta = 1'b1;
      3'h7: s.bus_to_thld = 1'b1;
    endcase
    return s;
  endfunction : decode_sel

  function automatic logic [3:0] level_lines(input logic [alsi_pkg::CTRL_LEVEL_W-1:0] lvl);
    return 4'(4'h1 << lvl);
  endfunction : level_lines

  // ----------------------------------------------------------------
  // Pin synchroniser and pulse generators
  // ----------------------------------------------------------------
  assign pins_raw = '{strobe:    master_sync_strobe,
                      match:     address_match,
                      dir:       direction_control,
                      c0:        byte_control,
                      a2:        reg_select_bit2,
                      a1:        reg_select_bit1,
                      a0:        byte_address_bit,
                      grant:     bus_grant,
                      vec_taken: vector_taken};

  alsi_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pins    (pins_raw),
    .pins_q  (pin)
  );

  alsi_oneshot #(
    .WIDTH_CYC (alsi_pkg::LOAD_PULSE_CNT)
  ) u_load_shot (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .trig    (st_ff.load_trig),
    .pulse   (load_busy)
  );

  alsi_oneshot #(
    .WIDTH_CYC (alsi_pkg::CLEAR_PULSE_CNT)
  ) u_clear_shot (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .trig    (st_ff.clr_trig),
    .pulse   (clr_busy)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.load_trig = 1'b0;
    nxt_st.clr_trig  = 1'b0;
    nxt_st.rdata     = '0;
    evt              = '0;
    // Odd-byte byte writes never enable the decoder
    addr_en = pin.strobe & pin.match & ~(pin.a0 & pin.dir & pin.c0);
    rx_cond = receive_irq_enable & receive_done_flag;
    tx_cond = transmit_irq_enable & transmit_ready_flag;

    // Bus slave cycle
    unique case (st_ff.bst)
      alsi_pkg::BUS_IDLE: begin
        if (addr_en) begin
          nxt_st.bst       = alsi_pkg::BUS_WAIT;
          nxt_st.cnt       = alsi_pkg::ACK_DELAY_CNT - alsi_pkg::CNT_ONE;
          nxt_st.sel       = decode_sel(pin.dir, pin.a2, pin.a1);
          nxt_st.load_trig = pin.dir & pin.a2 & pin.a1;
          nxt_st.clr_trig  = ~pin.a2 & pin.a1;
        end
      end
      alsi_pkg::BUS_WAIT: begin
        if (!pin.strobe) begin
          // Master gave up before the answer
          nxt_st.bst = alsi_pkg::BUS_IDLE;
          nxt_st.sel = alsi_pkg::SEL_NONE;
        end else if (st_ff.cnt != alsi_pkg::CNT_ZERO) begin
          nxt_st.cnt = st_ff.cnt - alsi_pkg::CNT_ONE;
        end else if (!st_ff.load_trig && !load_busy) begin
          nxt_st.bst = alsi_pkg::BUS_ACK;
          nxt_st.ack = 1'b1;
        end
      end
      alsi_pkg::BUS_ACK: begin
        if (!pin.strobe) begin
          nxt_st.bst = alsi_pkg::BUS_IDLE;
          nxt_st.ack = 1'b0;
          nxt_st.sel = alsi_pkg::SEL_NONE;
        end
      end
      default: begin
        nxt_st.bst = alsi_pkg::BUS_IDLE;
        nxt_st.ack = 1'b0;
        nxt_st.sel = alsi_pkg::SEL_NONE;
      end
    endcase

    // Re-arm a source only after its condition has been seen low
    if (!rx_cond) begin
      nxt_st.rx_armed = 1'b1;
    end
    if (!tx_cond) begin
      nxt_st.tx_armed = 1'b1;
    end
    rx_req = rx_cond & st_ff.rx_armed;
    tx_req = tx_cond & st_ff.tx_armed;

    // Interrupt request and vector; a stale grant or vector strobe would end the next vector unserved
    unique case (st_ff.ist)
      alsi_pkg::IRQ_IDLE: begin
        if (rx_req && !pin.grant && !pin.vec_taken) begin
          nxt_st.ist       = alsi_pkg::IRQ_REQ;
          nxt_st.src_tx    = 1'b0;
          nxt_st.req_lines = level_lines(st_ff.ctrl[alsi_pkg::CTRL_LEVEL_LSB +: alsi_pkg::CTRL_LEVEL_W]);
        end else if (tx_req && !pin.grant && !pin.vec_taken) begin
          nxt_st.ist       = alsi_pkg::IRQ_REQ;
          nxt_st.src_tx    = 1'b1;
          nxt_st.req_lines = level_lines(st_ff.ctrl[alsi_pkg::CTRL_LEVEL_LSB +: alsi_pkg::CTRL_LEVEL_W]);
        end
      end
      alsi_pkg::IRQ_REQ: begin
        if (st_ff.src_tx ? !tx_req : !rx_req) begin
          // Withdrawn: software cleared the enable or the flag
          nxt_st.ist       = alsi_pkg::IRQ_IDLE;
          nxt_st.req_lines = alsi_pkg::REQ_NONE;
        end else if (pin.grant) begin
          nxt_st.ist       = alsi_pkg::IRQ_VEC;
          nxt_st.req_lines = alsi_pkg::REQ_NONE;
          nxt_st.vec_data  = {st_ff.ctrl[alsi_pkg::CTRL_VEC_LSB +: alsi_pkg::CTRL_VEC_W],
                              st_ff.src_tx, 2'h0};
          nxt_st.vec_oe_n  = alsi_pkg::VEC_OE_N_DRIVE;
        end
      end
      alsi_pkg::IRQ_VEC: begin
        if (pin.vec_taken) begin
          nxt_st.ist      = alsi_pkg::IRQ_IDLE;
          nxt_st.vec_oe_n = alsi_pkg::VEC_OE_N_IDLE;
          nxt_st.vec_data = '0;
          if (st_ff.src_tx) begin
            nxt_st.tx_armed     = 1'b0;
            evt[alsi_pkg::EVT_TX_VEC] = 1'b1;
          end else begin
            nxt_st.rx_armed     = 1'b0;
            evt[alsi_pkg::EVT_RX_VEC] = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.ist       = alsi_pkg::IRQ_IDLE;
        nxt_st.req_lines = alsi_pkg::REQ_NONE;
        nxt_st.vec_oe_n  = alsi_pkg::VEC_OE_N_IDLE;
      end
    endcase

    evt[alsi_pkg::EVT_TX_LOAD]  = st_ff.load_trig;
    evt[alsi_pkg::EVT_RX_CLEAR] = st_ff.clr_trig;

    // Register port writes
    if (reg_wr) begin
      unique case (reg_addr)
        alsi_pkg::REG_CTRL:     nxt_st.ctrl = reg_wdata[alsi_pkg::CTRL_W-1:0];
        alsi_pkg::REG_IRQ_STAT: nxt_st.stat = st_ff.stat & ~reg_wdata[alsi_pkg::EVT_W-1:0];
        alsi_pkg::REG_IRQ_MASK: nxt_st.mask = reg_wdata[alsi_pkg::EVT_W-1:0];
        default: begin
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    nxt_st.stat = nxt_st.stat | evt;
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);

    // Register port reads
    if (reg_rd) begin
      unique case (reg_addr)
        alsi_pkg::REG_CTRL:     nxt_st.rdata = {8'h00, st_ff.ctrl};
        alsi_pkg::REG_IRQ_STAT: nxt_st.rdata = {12'h000, st_ff.stat};
        alsi_pkg::REG_IRQ_MASK: nxt_st.rdata = {12'h000, st_ff.mask};
        alsi_pkg::REG_STATE:    nxt_st.rdata = {2'h0, st_ff.bst, st_ff.ist, st_ff.ack, st_ff.src_tx,
                                                st_ff.rx_armed, st_ff.tx_armed, st_ff.req_lines};
        default:                nxt_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.bst       <= alsi_pkg::BUS_IDLE;
      st_ff.cnt       <= alsi_pkg::CNT_ZERO;
      st_ff.sel       <= alsi_pkg::SEL_NONE;
      st_ff.ack       <= 1'b0;
      st_ff.load_trig <= 1'b0;
      st_ff.clr_trig  <= 1'b0;
      st_ff.ist       <= alsi_pkg::IRQ_IDLE;
      st_ff.src_tx    <= 1'b0;
      st_ff.rx_armed  <= 1'b1;
      st_ff.tx_armed  <= 1'b1;
      st_ff.req_lines <= alsi_pkg::REQ_NONE;
      st_ff.vec_data  <= '0;
      st_ff.vec_oe_n  <= alsi_pkg::VEC_OE_N_IDLE;
      st_ff.ctrl      <= alsi_pkg::CTRL_RESET;
      st_ff.stat      <= alsi_pkg::EVT_RESET;
      st_ff.mask      <= alsi_pkg::EVT_RESET;
      st_ff.rdata     <= '0;
      st_ff.irq       <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata           = st_ff.rdata;
  assign reg_select          = st_ff.sel;
  assign slave_sync_ack      = st_ff.ack;
  assign transmit_load_pulse = load_busy;
  assign receive_clear_pulse = clr_busy;
  assign request_lines       = st_ff.req_lines;
  assign vector_data         = st_ff.vec_data;
  assign vector_oe_n         = st_ff.vec_oe_n;
  assign irq                 = st_ff.irq;

endmodule : alsi_line_bus_slave

// >>> verification/alsi_line_props.sv
`timescale 1ns/1ps
module alsi_line_props (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                master_sync_strobe,
  input wire logic                direction_control,
  input wire logic                byte_control,
  input wire logic                byte_address_bit,
  input wire logic                receive_done_flag,
  input wire logic                transmit_ready_flag,
  input wire logic                receive_irq_enable,
  input wire logic                transmit_irq_enable,
  input wire alsi_pkg::alsi_sel_t reg_select,
  input wire logic                slave_sync_ack,
  input wire logic                transmit_load_pulse,
  input wire logic                receive_clear_pulse,
  input wire logic [3:0]          request_lines,
  input wire logic [8:0]          vector_oe_n
);
  // ----------------------------------------------------------------
  // Select age, saturating so a stuck select cannot wrap to 80
  // ----------------------------------------------------------------
  logic [7:0] sel_age_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sel_age_ff <= 8'h00;
    else if (reg_select == alsi_pkg::SEL_NONE) sel_age_ff <= 8'h00;
    else if (sel_age_ff != 8'hFF) sel_age_ff <= sel_age_ff + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sel_onehot_a: assert property ($onehot0(reg_select))
    else $error("two selects at once");
  odd_byte_a: assert property (master_sync_strobe && direction_control && byte_control && byte_address_bit
    |-> reg_select == alsi_pkg::SEL_NONE && !slave_sync_ack) else $error("odd byte write acted");
  ack_delay_a: assert property ($rose(slave_sync_ack) && (|reg_select) |-> sel_age_ff == 8'h50)
    else $error("ack delay wrong");
  load_cause_a: assert property ($rose(transmit_load_pulse) |-> $past(reg_select.bus_to_thld))
    else $error("load pulse without buffer write");
  load_width_a: assert property ($rose(transmit_load_pulse) |-> transmit_load_pulse [*8]
    ##22 transmit_load_pulse ##1 !transmit_load_pulse) else $error("load pulse width");
  ack_holdoff_a: assert property (slave_sync_ack |-> !transmit_load_pulse)
    else $error("ack during load pulse");
  clear_cause_a: assert property ($rose(receive_clear_pulse)
    |-> $past(reg_select.rhld_to_bus || reg_select.bus_to_rhld)) else $error("clear pulse without access");
  req_level_a: assert property ($onehot0(request_lines))
    else $error("more than one request level");
  req_cause_a: assert property ($rose(|request_lines) |-> $past(receive_irq_enable && receive_done_flag
    || transmit_irq_enable && transmit_ready_flag)) else $error("request without cause");
  vec_drive_a: assert property (vector_oe_n != alsi_pkg::VEC_OE_N_IDLE
    |-> vector_oe_n == alsi_pkg::VEC_OE_N_DRIVE) else $error("vector drive pattern");
  ack_hold_a: assert property (slave_sync_ack && master_sync_strobe |=> slave_sync_ack)
    else $error("ack dropped under strobe");
endmodule : alsi_line_props
bind alsi_line_bus_slave alsi_line_props u_props (.sys_clk, .rstn, .master_sync_strobe, .direction_control,
  .byte_control, .byte_address_bit, .receive_done_flag, .transmit_ready_flag, .receive_irq_enable,
  .transmit_irq_enable, .reg_select, .slave_sync_ack, .transmit_load_pulse, .receive_clear_pulse,
  .request_lines, .vector_oe_n);

// >>> verification/alsi_host_model.sv
`timescale 1ns/1ps
module alsi_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] request_lines,
  input  wire logic [8:0] vector_data,
  input  wire logic [8:0] vector_oe_n,
  input  wire logic [3:0] lag,
  output logic            bus_grant,
  output logic            vector_taken,
  output logic [8:0]      vec_seen,
  output logic [3:0]      req_seen
);
  // ----------------------------------------------------------------
  // Arbiter: grant after lag+1 cycles of request, strobe vector, free the bus
  // ----------------------------------------------------------------
  logic [3:0] cnt_ff;
  logic       drive;
  assign drive = (vector_oe_n == alsi_pkg::VEC_OE_N_DRIVE);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {bus_grant, vector_taken, cnt_ff, vec_seen, req_seen} <= '0;
    end else if (vector_taken && !drive) begin
      bus_grant    <= 1'b0;
      vector_taken <= 1'b0;
      cnt_ff       <= 4'h0;
    end else if (bus_grant && drive) begin
      vector_taken <= 1'b1;
      vec_seen     <= vector_data;
    end else if (!bus_grant && (|request_lines || drive)) begin
      // A stale grant may already have started a vector, so drive counts too
      if (|request_lines) req_seen <= request_lines;
      cnt_ff    <= cnt_ff + 4'h1;
      bus_grant <= (cnt_ff >= lag);
    end
  end
endmodule : alsi_host_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
  logic sys_clk, rstn, master_sync_strobe, address_match, direction_control, byte_control;
  logic reg_select_bit2, reg_select_bit1, byte_address_bit, bus_grant, vector_taken, reg_wr, reg_rd;
  logic receive_done_flag, transmit_ready_flag, receive_irq_enable, transmit_irq_enable;
  logic slave_sync_ack, transmit_load_pulse, receive_clear_pulse, irq, got_ack, ok;
  logic [3:0] reg_addr, request_lines, lag, req_seen, st;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [8:0] vector_data, vector_oe_n, vec_seen;
  logic [6:0] sel_seen, load_seen, clr_seen;
  logic [4:0] p;
  logic [31:0] seed, r;
  alsi_pkg::alsi_sel_t reg_select;
  int err_total, tests_run, cyc;
  alsi_line_bus_slave DUT (.sys_clk, .rstn, .master_sync_strobe, .address_match, .direction_control,
    .byte_control, .reg_select_bit2, .reg_select_bit1, .byte_address_bit, .bus_grant, .vector_taken,
    .receive_done_flag, .transmit_ready_flag, .receive_irq_enable, .transmit_irq_enable, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_select, .slave_sync_ack, .transmit_load_pulse,
    .receive_clear_pulse, .request_lines, .vector_data, .vector_oe_n, .irq);
  alsi_host_model u_host (.sys_clk, .rstn, .request_lines, .vector_data, .vector_oe_n, .lag, .bus_grant,
    .vector_taken, .vec_seen, .req_seen);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [6:0] exp_sel(input logic d, input logic a2, input logic a1);
    return d ? 7'h08 >> {a2, a1} : ((a2 & a1) ? 7'h00 : 7'h40 >> {a2, a1});
  endfunction : exp_sel
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic bus(input logic [4:0] c, input logic m);
    int n;
    @(posedge sys_clk);
    {direction_control, byte_control, reg_select_bit2, reg_select_bit1, byte_address_bit} <= c;
    address_match      <= m;
    master_sync_strobe <= 1'b1;
    {sel_seen, load_seen, clr_seen, got_ack} = '0;
    // Lines stay put until the ack, so the load pulse sees stable data
    for (n = 0; n < 150 && !got_ack; n++) begin
      @(posedge sys_clk);
      #1 sel_seen |= reg_select;
      load_seen |= transmit_load_pulse;
      clr_seen  |= receive_clear_pulse;
      got_ack = slave_sync_ack;
    end
    @(posedge sys_clk);
    master_sync_strobe <= 1'b0;
    {direction_control, byte_control, reg_select_bit2, reg_select_bit1, byte_address_bit} <= ~c;
    address_match <= ~m;
    repeat (12) @(posedge sys_clk);
  endtask : bus
  task automatic take(input logic [8:0] ev, input logic [3:0] el);
    int n;
    for (n = 0; n < 300 && vector_taken !== 1'b1; n++) @(posedge sys_clk);
    #1 `CHK(vec_seen & 9'h1FC, ev)
    `CHK(req_seen, el)
    for (n = 0; n < 300 && vector_taken === 1'b1; n++) @(posedge sys_clk);
  endtask : take
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, master_sync_strobe, address_match, direction_control, byte_control, reg_wr, reg_rd} = '0;
    {reg_select_bit2, reg_select_bit1, byte_address_bit, reg_addr, reg_wdata, st} = '0;
    {receive_done_flag, transmit_ready_flag, receive_irq_enable, transmit_irq_enable} = '0;
    {err_total, tests_run, cyc} = '0;
    lag  = 4'h1;
    seed = 32'h00006B9D;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    r = xs();
    wr(4'h2, r[15:0]);
    rd(4'h2, v);
    `CHK(v, 16'h0000)
    rd(alsi_pkg::REG_CTRL, v);
    `CHK(v, 16'h0006)
    for (int i = 0; i < 14; i++) begin
      r = xs();
      p = (i < 8 || i == 13) ? {i[2], 1'b0, i[1], i[0], 1'b0} : {2'b11, r[2:1], i[0]};
      bus(p, i != 13);
      ok = (i != 13) && !(p[4] & p[3] & p[0]);
      `CHK(sel_seen, ok ? exp_sel(p[4], p[2], p[1]) : 7'h00)
      `CHK(got_ack, ok)
      `CHK(load_seen[0], ok & p[4] & p[2] & p[1])
      `CHK(clr_seen[0], ok & !p[2] & p[1])
      st |= {2'b00, ok & !p[2] & p[1], ok & p[4] & p[2] & p[1]};
    end
    $display("done: bus decode");
    `CHK(irq, 1'b0)
    wr(alsi_pkg::REG_IRQ_MASK, 16'h0001);
    @(posedge sys_clk);
    #1 `CHK(irq, 1'b1)
    wr(alsi_pkg::REG_IRQ_STAT, 16'h0001);
    st &= 4'hE;
    rd(alsi_pkg::REG_IRQ_STAT, v);
    `CHK(v, {12'h000, st})
    `CHK(irq, 1'b0)
    $display("done: event register");
    @(posedge sys_clk);
    {receive_done_flag, transmit_ready_flag, receive_irq_enable, transmit_irq_enable} <= 4'hF;
    take(9'h030, 4'h1);
    take(9'h034, 4'h1);
    st |= 4'hC;
    repeat (60) @(posedge sys_clk);
    `CHK(request_lines, 4'h0)
    $display("done: priority and rearm");
    lag <= 4'h9;
    wr(alsi_pkg::REG_CTRL, 16'h00BF);
    receive_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    receive_irq_enable <= 1'b1;
    take(9'h1F8, 4'h4);
    rd(alsi_pkg::REG_IRQ_STAT, v);
    `CHK(v, {12'h000, st})
    $display("done: vector base and level");
    wrap_up();
  end
endmodule : testbench
